// [hdl/sbo_arbiter.sv]
`timescale 1ns/1ps

// Operation
// [R1] Raise release request when a higher ranked request appears under external ownership.
// [R2] Raise release request when the core needs the bus under an ET grant.
// [R3] A master seeing release request drops its ownership line and request.
// [R4] A surrendering master may keep requesting to be arbitrated again.
// [R5] A granted master raises ownership before driving, stops when done.
// [R6] Drop the grant after sampling ownership line released; core owns again.
// [R7] A master holds ownership line for as long as it drives the bus.
// [R8] Using the master's output enable as ownership line is recommended.
// [R9] A master dropping its low ET request also drops ownership line.
// [R10] Assert low ET grant the cycle after its request is sampled low.
// [R11] Hold off any grant while the core runs its own bus cycle.
// [R12] Drop low ET grant when ownership line or request is sampled high.
// [R13] First grant cycle is dead; master drives only from the next cycle.
// [R14] Cycle where master releases ownership line is dead for both sides.
// [R15] In a daisy chain the shared request is the OR of member requests.
// [R16] A request still held after core regains bus is granted next cycle.
// [R17] Drop grant and release request together; pending core cycle starts.
// [R18] After a release the bus goes to the core or higher external requester.
// [R19] A master may take cycles finishing its transfer after release request.
// [R20] Masters may watch each other's ownership line to adjust requests.
// [R21] Rank hi shared, hi ET, lo shared, lo ET; steal only on ET.
// [R22] Never raise a cycle steal release request under shared transfer grant.
// [R23] All handshake lines are active low and registered on the rising edge; core_bus_req and core_bus_busy are active high and used unregistered.
module sbo_arbiter (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  sbo_pkg::sbo_req_s        req_n,
  input  wire logic                owner_drives_n,
  input  wire logic                core_bus_req,
  input  wire logic                core_bus_busy,
  output sbo_pkg::sbo_grant_s      grant_n,
  output logic                     release_request_n,
  output logic                     core_bus_owned,
  output sbo_pkg::sbo_owner_e      owner
);

  // Sampled handshake inputs
  sbo_pkg::sbo_req_s   req_reg;
  sbo_pkg::sbo_req_s   req_next;
  logic                drives_reg;
  logic                drives_next;

  // Arbiter state
  sbo_pkg::sbo_state_e state_reg;
  sbo_pkg::sbo_state_e state_next;
  sbo_pkg::sbo_owner_e owner_reg;
  sbo_pkg::sbo_owner_e owner_next;
  sbo_pkg::sbo_grant_s grant_reg;
  sbo_pkg::sbo_grant_s grant_next;
  logic                release_reg;
  logic                release_next;

  // Priority pick over the sampled requests
  sbo_pkg::sbo_owner_e pick;
  logic                pick_any;
  logic                owner_req_n;
  logic                owner_is_et;
  logic                drop;
  logic                steal;

  sbo_prio_pick u_pick (
    .req_n    (req_reg),
    .pick     (pick),
    .pick_any (pick_any)
  );

  // Input sampling; request and ownership lines are registered, core_bus_req and core_bus_busy are used unregistered
  always_comb begin
    req_next    = req_n;          // [R23]
    drives_next = owner_drives_n; // [R23]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_reg    <= sbo_pkg::SBO_REQ_IDLE;
      drives_reg <= sbo_pkg::SBO_LINE_IDLE;
    end else begin
      req_reg    <= req_next;
      drives_reg <= drives_next;
    end
  end

  // Grant line pattern for one owner
  function automatic sbo_pkg::sbo_grant_s grant_of(input sbo_pkg::sbo_owner_e who);
    sbo_pkg::sbo_grant_s g;
    g = sbo_pkg::SBO_GRANT_IDLE;
    unique case (who)
      sbo_pkg::SBO_OWN_LO_ET:     g.lo_et_n     = 1'b0;
      sbo_pkg::SBO_OWN_LO_SHARED: g.lo_shared_n = 1'b0;
      sbo_pkg::SBO_OWN_HI_ET:     g.hi_et_n     = 1'b0;
      sbo_pkg::SBO_OWN_HI_SHARED: g.hi_shared_n = 1'b0;
      default:                    g = sbo_pkg::SBO_GRANT_IDLE;
    endcase
    return g;
  endfunction

  // Current owner's own request line and transfer kind
  always_comb begin
    owner_req_n = 1'b1;
    owner_is_et = 1'b0;
    unique case (owner_reg)
      sbo_pkg::SBO_OWN_LO_ET: begin
        owner_req_n = req_reg.lo_et_n;
        owner_is_et = 1'b1;
      end
      sbo_pkg::SBO_OWN_LO_SHARED: begin
        owner_req_n = req_reg.lo_shared_n;
      end
      sbo_pkg::SBO_OWN_HI_ET: begin
        owner_req_n = req_reg.hi_et_n;
        owner_is_et = 1'b1;
      end
      sbo_pkg::SBO_OWN_HI_SHARED: begin
        owner_req_n = req_reg.hi_shared_n;
      end
      default: begin
        owner_req_n = 1'b1;
        owner_is_et = 1'b0;
      end
    endcase
  end

  // Core steal only ever targets an ET owner; shared owners keep the bus
  assign steal = core_bus_req && owner_is_et; // [R2] [R22] [R21]

  // Release of an external owner. A missing ownership line in the dead
  // grant cycle is normal, so only the request line counts there.
  always_comb begin
    unique case (state_reg)
      sbo_pkg::SBO_ST_GRANTED: drop = owner_req_n;              // [R12]
      sbo_pkg::SBO_ST_DRIVEN:  drop = owner_req_n || drives_reg; // [R6] [R12]
      default:                 drop = 1'b0;
    endcase
  end

  // Ownership state machine
  always_comb begin
    state_next   = state_reg;
    owner_next   = owner_reg;
    release_next = release_reg;
    unique case (state_reg)
      sbo_pkg::SBO_ST_CORE: begin
        // Core first when it waits on the bus; busy core defers grants
        if (pick_any && !core_bus_busy && !core_bus_req) begin // [R11] [R18]
          state_next = sbo_pkg::SBO_ST_GRANTED; // [R10] [R13] [R16]
          owner_next = pick;
        end
      end
      sbo_pkg::SBO_ST_GRANTED,
      sbo_pkg::SBO_ST_DRIVEN: begin
        if (drop) begin
          // Grant and release request lines rise together, core owns next cycle
          state_next   = sbo_pkg::SBO_ST_CORE;       // [R17] [R14]
          owner_next   = sbo_pkg::SBO_OWN_CORE;
          release_next = 1'b0;                       // [R17]
        end else begin
          if (!drives_reg) begin
            state_next = sbo_pkg::SBO_ST_DRIVEN;
          end
          if ((pick > owner_reg) || steal) begin
            release_next = 1'b1;                     // [R1] [R2]
          end
        end
      end
      default: begin
        state_next   = sbo_pkg::SBO_ST_CORE;
        owner_next   = sbo_pkg::SBO_OWN_CORE;
        release_next = 1'b0;
      end
    endcase
    grant_next = grant_of(owner_next);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= sbo_pkg::SBO_ST_CORE;
      owner_reg   <= sbo_pkg::SBO_OWN_CORE;
      grant_reg   <= sbo_pkg::SBO_GRANT_IDLE;
      release_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      owner_reg   <= owner_next;
      grant_reg   <= grant_next;
      release_reg <= release_next;
    end
  end

  // Outputs straight from flip-flops except core_bus_owned, decoded from state_reg
  assign grant_n           = grant_reg;
  assign release_request_n = ~release_reg;
  assign owner             = owner_reg;
  // Core may drive only with no grant out; grant cycles stay dead
  assign core_bus_owned    = (state_reg == sbo_pkg::SBO_ST_CORE); // [R13] [R14]

endmodule

// [common/sbo_pkg.sv]
package sbo_pkg;

  // Request lines as seen by the arbiter, all active low
  typedef struct packed {
    logic hi_shared_n;
    logic hi_et_n;
    logic lo_shared_n;
    logic lo_et_n;
  } sbo_req_s;

  // Grant lines driven by the arbiter, all active low
  typedef struct packed {
    logic hi_shared_n;
    logic hi_et_n;
    logic lo_shared_n;
    logic lo_et_n;
  } sbo_grant_s;

  // Bus owner; codes rise with priority so a plain compare ranks them
  typedef enum logic [2:0] {
    SBO_OWN_CORE      = 3'b000,
    SBO_OWN_LO_ET     = 3'b001,
    SBO_OWN_LO_SHARED = 3'b010,
    SBO_OWN_HI_ET     = 3'b011,
    SBO_OWN_HI_SHARED = 3'b100
  } sbo_owner_e;

  // Arbiter phase
  typedef enum logic [1:0] {
    SBO_ST_CORE    = 2'b00,
    SBO_ST_GRANTED = 2'b01,
    SBO_ST_DRIVEN  = 2'b10
  } sbo_state_e;

  // Reset values
  localparam sbo_req_s   SBO_REQ_IDLE   = 4'hF;
  localparam sbo_grant_s SBO_GRANT_IDLE = 4'hF;
  localparam logic       SBO_LINE_IDLE  = 1'b1;

endpackage

// [hdl/sbo_prio_pick.sv]
`timescale 1ns/1ps

// Picks the highest ranked active request
module sbo_prio_pick (
  input  sbo_pkg::sbo_req_s   req_n,
  output sbo_pkg::sbo_owner_e pick,
  output logic                pick_any
);

  // Fixed ranking: hi shared, hi ET, lo shared, lo ET
  always_comb begin
    pick_any = 1'b1;
    if (!req_n.hi_shared_n) begin // [R21]
      pick = sbo_pkg::SBO_OWN_HI_SHARED;
    end else if (!req_n.hi_et_n) begin
      pick = sbo_pkg::SBO_OWN_HI_ET;
    end else if (!req_n.lo_shared_n) begin
      pick = sbo_pkg::SBO_OWN_LO_SHARED;
    end else if (!req_n.lo_et_n) begin
      pick = sbo_pkg::SBO_OWN_LO_ET;
    end else begin
      pick     = sbo_pkg::SBO_OWN_CORE;
      pick_any = 1'b0;
    end
  end

endmodule

// [tb/sbo_arbiter_assertions.sv]
`timescale 1ns/1ps
// Port checker; every handshake is judged on the rising edge
module sbo_arbiter_assertions (
  input wire logic          clk_sys,
  input wire logic          rst,
  input sbo_pkg::sbo_req_s   req_n,
  input wire logic          owner_drives_n,
  input wire logic          core_bus_req,
  input wire logic          core_bus_busy,
  input sbo_pkg::sbo_grant_s grant_n,
  input wire logic          release_request_n,
  input wire logic          core_bus_owned,
  input sbo_pkg::sbo_owner_e owner
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Grant timing is tied to the registered request, two samples back
  a_busy_holds: assert property (&grant_n && core_bus_busy |=> &grant_n)
    else $error("grant in core cycle");
  a_lo_cause: assert property ($fell(grant_n.lo_et_n) |-> !$past(req_n.lo_et_n, 2))
    else $error("grant without request");
  a_lo_drop: assert property (!grant_n.lo_et_n && req_n.lo_et_n |-> ##2 grant_n.lo_et_n)
    else $error("grant kept");
  a_rel_with_grant: assert property ($rose(release_request_n) |-> $rose(&grant_n))
    else $error("release rose alone");
  a_no_shared_steal: assert property (
    $fell(release_request_n) && owner == sbo_pkg::SBO_OWN_LO_SHARED
    |-> !$past(req_n.hi_shared_n, 2) || !$past(req_n.hi_et_n, 2))
    else $error("steal under shared grant");
  a_et_steal: assert property (
    (!grant_n.lo_et_n && !req_n.lo_et_n && !owner_drives_n && core_bus_req) [*2]
    |=> !release_request_n) else $error("no steal release");
  a_regrant: assert property (
    $rose(grant_n.lo_et_n) && !req_n.lo_et_n && &req_n[3:1]
    ##1 !req_n.lo_et_n && &req_n[3:1] && !core_bus_req && !core_bus_busy
    |=> !grant_n.lo_et_n) else $error("no regrant");
  a_dead_cycle: assert property ($fell(&grant_n) |-> !core_bus_owned)
    else $error("grant cycle not dead");
endmodule

bind sbo_arbiter sbo_arbiter_assertions chk_u (.clk_sys, .rst, .req_n, .owner_drives_n,
  .core_bus_req, .core_bus_busy, .grant_n, .release_request_n, .core_bus_owned, .owner);

// [tb/sbo_master_model.sv]
`timescale 1ns/1ps
// External master on one request/grant pair; LEN sets transfer length
module sbo_master_model #(
  parameter int LEN = 8
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic keep,
  input  wire logic grant_n,
  input  wire logic release_request_n,
  output logic      req_n = 1'b1,
  output logic      owner_drives_n = 1'b1
);
  int   cnt = 0;
  logic done = 1'b0;
  // Ownership line doubles as this master's output enable
  always @(posedge clk_sys) begin
    if (rst) begin
      req_n <= 1'b1;
      owner_drives_n <= 1'b1;
      done <= 1'b0;
    end else if (!owner_drives_n) begin
      cnt <= cnt + 1;
      if (cnt == LEN || !release_request_n) begin
        owner_drives_n <= 1'b1;
        req_n <= !keep;
        done <= 1'b1;
      end
    end else if (!grant_n && !done && !req_n) begin
      owner_drives_n <= 1'b0;
      cnt <= 0;
    end else if (grant_n) begin
      done <= 1'b0;
      req_n <= !go;
    end
  end
endmodule

// [tb/tb_system_bus_ownership_arbiter.sv]
`timescale 1ns/1ps
module tb_system_bus_ownership_arbiter;
  logic clk_sys = 0, rst = 1, cbr = 0, cbb = 0, hs_n = 1, ls_n = 1, od_n = 1;
  logic go1 = 0, keep1 = 0, r1_n, o1_n, rel_n, owned;
  sbo_pkg::sbo_grant_s grant_n;
  sbo_pkg::sbo_owner_e owner;
  int n_fail = 0, checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  // Shared-transfer lines are driven by the bench in a master's place;
  // the lo ET line is a chain of one, so its combined request is r1_n
  sbo_arbiter dut_u (.clk_sys, .rst, .req_n({hs_n, 1'b1, ls_n, r1_n}),
    .owner_drives_n(o1_n & od_n), .core_bus_req(cbr), .core_bus_busy(cbb),
    .grant_n, .release_request_n(rel_n), .core_bus_owned(owned), .owner);
  sbo_master_model #(.LEN(8)) m1_u (.clk_sys, .rst, .go(go1), .keep(keep1),
    .grant_n(grant_n.lo_et_n), .release_request_n(rel_n), .req_n(r1_n), .owner_drives_n(o1_n));
  task automatic chk(input logic [3:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait, so a missing grant shows as a mismatch, not a hang
  task automatic wg(input logic [3:0] exp);
    for (int i = 0; i < 40 && grant_n !== exp; i++) @(posedge clk_sys) #1;
    chk(grant_n, exp);
  endtask
  task automatic t_single;
    @(posedge clk_sys);
    cbb <= 1;
    go1 <= 1;
    keep1 <= 1;
    repeat (6) @(posedge clk_sys);
    #1 chk(grant_n, 4'hF);
    @(posedge clk_sys);
    cbb <= 0;
    wg(4'hE);
    chk({owned, owner}, 4'h1);
    wg(4'hF);
    chk({owned, owner}, 4'h8);
    wg(4'hE);
    @(posedge clk_sys);
    go1 <= 0;
    keep1 <= 0;
    wg(4'hF);
    $display("single done");
  endtask
  task automatic t_steal;
    @(posedge clk_sys);
    go1 <= 1;
    wg(4'hE);
    @(posedge clk_sys);
    cbr <= 1;
    go1 <= 0;
    for (int i = 0; i < 9 && rel_n !== 0; i++) @(posedge clk_sys) #1;
    chk(rel_n, 0);
    wg(4'hF);
    chk({rel_n, owned}, 4'h3);
    @(posedge clk_sys);
    cbr <= 0;
    $display("steal done");
  endtask
  task automatic t_shared;
    @(posedge clk_sys);
    ls_n <= 0;
    wg(4'hD);
    @(posedge clk_sys);
    od_n <= 0;
    cbr <= 1;
    repeat (5) @(posedge clk_sys);
    #1 chk(rel_n, 1);
    @(posedge clk_sys);
    cbr <= 0;
    hs_n <= 0;
    repeat (3) @(posedge clk_sys);
    #1 chk(rel_n, 0);
    @(posedge clk_sys);
    od_n <= 1;
    ls_n <= 1;
    wg(4'h7);
    chk({owned, owner}, 4'h4);
    @(posedge clk_sys);
    hs_n <= 1;
    wg(4'hF);
    $display("shared done");
  endtask
  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Tests need under 100 cycles; far past that means a hang
  initial begin
    #20us;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    repeat (2) @(posedge clk_sys);
    t_single;
    t_steal;
    t_shared;
    test_done;
  end
endmodule
